// ==== hdl/adcr_params.svh ====
// offsets, field positions, reset values and counts of the converter
// clock and pin configuration bank; holds definitions only
`ifndef ADCR_PARAMS_SVH
`define ADCR_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (15-bit serial port address space)
// ----------------------------------------------------------------------
`define ADCR_OFS_TEMP_DIODE   15'h0028
`define ADCR_OFS_FULLSCALE    15'h0030
`define ADCR_OFS_PD_PIN_EN    15'h003F
`define ADCR_OFS_PIN_ROUTE    15'h0040
`define ADCR_OFS_DIV_RATIO    15'h010B
`define ADCR_OFS_DIV_PHASE    15'h010C
`define ADCR_OFS_AUTOPHASE    15'h010D
`define ADCR_OFS_FINE_DLY     15'h0117

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ADCR_RST_TEMP_DIODE   8'h00
`define ADCR_RST_FULLSCALE    8'h04
`define ADCR_RST_PD_PIN_EN    8'h00
`define ADCR_RST_PIN_ROUTE    8'h3F
`define ADCR_RST_DIV_RATIO    8'h00
`define ADCR_RST_DIV_PHASE    8'h00
`define ADCR_RST_AUTOPHASE    8'h00
`define ADCR_RST_FINE_DLY     8'h00

// ----------------------------------------------------------------------
// writable bit masks (all other bits reserved, read as zero)
// ----------------------------------------------------------------------
`define ADCR_MSK_TEMP_DIODE   8'h01
`define ADCR_MSK_FULLSCALE    8'h0C
`define ADCR_MSK_PD_PIN_EN    8'h80
`define ADCR_MSK_PIN_ROUTE    8'hFF
`define ADCR_MSK_DIV_RATIO    8'h07
`define ADCR_MSK_DIV_PHASE    8'h0F
`define ADCR_MSK_AUTOPHASE    8'h8F
`define ADCR_MSK_FINE_DLY     8'h01

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ADCR_BIT_DIODE_SEL    0
`define ADCR_FS_LSB           2
`define ADCR_BIT_PD_IGNORE    7
`define ADCR_SLEEP_FN_LSB     6
`define ADCR_ROUTE_B_LSB      3
`define ADCR_ROUTE_A_LSB      0
`define ADCR_BIT_AUTOPHASE    7
`define ADCR_NEG_WIN_LSB      2
`define ADCR_POS_WIN_LSB      0
`define ADCR_BIT_FINE_DLY     0

// ----------------------------------------------------------------------
// codes and counts
// ----------------------------------------------------------------------
`define ADCR_SLEEP_FN_PDWN    2'h0
`define ADCR_SLEEP_FN_STBY    2'h1
`define ADCR_ROUTE_DETECT     3'h0
`define ADCR_ROUTE_DIODE      3'h3
`define ADCR_ROUTE_OFF        3'h7
`define ADCR_DP_RST_CYCLES    3'h4

`endif

// ==== hdl/adcr_pkg.sv ====
// types shared by the configuration bank and its clock divider
// assumes adcr_params.svh is on the include path
`include "adcr_params.svh"

package adcr_pkg;

    typedef enum logic {
        SPI_INSTR,
        SPI_DATA
    } adcr_spi_state_type;

    // divider ratio code to divide factor; undefined codes divide by 1
    function automatic logic [3:0] adcr_ratio(input logic [2:0] code);
        case (code)
            3'h1:    adcr_ratio = 4'h2;
            3'h3:    adcr_ratio = 4'h4;
            3'h7:    adcr_ratio = 4'h8;
            default: adcr_ratio = 4'h1;
        endcase
    endfunction : adcr_ratio

    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] dly;
        logic       clk;
        logic       tick;
    } adcr_div_state_type;

    typedef struct packed {
        logic [2:0]         csb_sync;
        logic [2:0]         sclk_sync;
        logic [1:0]         sdio_sync;
        logic [1:0]         sleep_sync;
        logic [2:0]         sync_sync;
        adcr_spi_state_type st;
        logic [3:0]         bit_cnt;
        logic [15:0]        shift;
        logic [14:0]        addr;
        logic               rd;
        logic [7:0]         tx;
        logic               oe;
        logic [7:0]         temp_diode;
        logic [7:0]         fullscale;
        logic [7:0]         pd_pin_en;
        logic [7:0]         pin_route;
        logic [7:0]         div_ratio;
        logic [7:0]         div_phase;
        logic [7:0]         autophase;
        logic [7:0]         fine_dly;
        logic [2:0]         dp_rst_cnt;
        logic               dp_rst;
        logic [2:0]         frame_pos;
        logic               realign;
        logic               pd;
        logic               sb;
        logic               alarm_a;
        logic               alarm_a_oe;
        logic               alarm_b;
        logic               alarm_b_oe;
        logic               diode_a;
    } adcr_regs_state_type;

endpackage : adcr_pkg

// ==== hdl/adcr_div_if.sv ====
// carrier between the configuration bank and the sample clock divider
// assumes both ends run on mclk
`timescale 1ns/1ps
`default_nettype none

interface adcr_div_if;
    logic [2:0] ratio_code;
    logic [3:0] phase_code;
    logic       realign;
    logic       dev_clk;
    logic       dev_tick;
    logic       half_shift;

    modport ctrl (
        output ratio_code,
        output phase_code,
        output realign,
        input  dev_clk,
        input  dev_tick,
        input  half_shift
    );

    modport div (
        input  ratio_code,
        input  phase_code,
        input  realign,
        output dev_clk,
        output dev_tick,
        output half_shift
    );
endinterface : adcr_div_if

`default_nettype wire

// ==== hdl/adcr_clkdiv.sv ====
// sample clock divider with whole-cycle phase delay
// assumes mclk is the converter input clock and rst is already synced
`timescale 1ns/1ps
`default_nettype none

module adcr_clkdiv
    import adcr_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_sync_n,
    adcr_div_if.div   div
);
    adcr_div_state_type r_ff;
    adcr_div_state_type nxt_r;

    always_comb begin
        logic [3:0] n;
        logic       tap;
        n     = 4'h0;
        tap   = 1'b0;
        nxt_r = r_ff;
        n     = adcr_ratio(div.ratio_code);
        if (div.realign || ({1'b0, r_ff.cnt} >= n - 4'h1)) begin
            nxt_r.cnt = 3'h0;
        end else begin
            nxt_r.cnt = r_ff.cnt + 3'h1;
        end
        nxt_r.dly = {r_ff.dly[6:0], ({1'b0, r_ff.cnt} < (n >> 1))};
        // whole input cycles from the tap, half cycle left to the
        // analog delay cell since logic sees only one edge
        tap       = r_ff.dly[div.phase_code[3:1]];
        nxt_r.clk = (n == 4'h1) ? 1'b1 : tap;
        nxt_r.tick = (n == 4'h1) ? 1'b1 : (tap & ~r_ff.clk);
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign div.dev_clk    = r_ff.clk;
    assign div.dev_tick   = r_ff.tick;
    assign div.half_shift = div.phase_code[0];
endmodule : adcr_clkdiv

`default_nettype wire

// ==== hdl/adcr_regs.sv ====
// clock and pin configuration bank of a dual sampling converter,
// reached over the three-wire serial control port
// assumes serial pins toggle far slower than mclk (sclk <= mclk/8)
//
// Function
// - diode select bit 0 set enables temperature diode, clear none.
// - full-scale code 01 for range >= 1.82 V, 10 below; reset 0x04.
// - bit 7 clear honours sleep pin, set ignores it.
// - sleep function 00 powers down, 01 standby, other codes off.
// - alarm A route 000 drives detect flag, 111 disables pin.
// - alarm A route 011 puts temperature diode onto pin A.
// - alarm B route 000 drives detect flag, 111 disables pin.
// - divider code 000/001/011/111 divides by 1/2/4/8.
// - divider phase delays half input cycle per code step.
// - autophase bit 7 enables divider realignment from sync input.
// - positive skew window tolerates 0 to 2 device clocks.
// - enabling fine delay sets fine delay and starts datapath reset.
// - datapath soft reset clears itself after it is done.
`timescale 1ns/1ps
`default_nettype none
`include "adcr_params.svh"

module adcr_regs
    import adcr_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       spi_csb_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_sdio_in,
    output logic            spi_sdio_out,
    output logic            spi_sdio_oe,
    input  wire logic       sleep_control_pin,
    input  wire logic       sync_pin,
    input  wire logic       fast_detect_a,
    input  wire logic       fast_detect_b,
    output logic            temp_diode_en,
    output logic [1:0]      fullscale_code,
    output logic            powerdown_req,
    output logic            standby_req,
    output logic            level_alarm_pin_a,
    output logic            level_alarm_pin_a_oe,
    output logic            level_alarm_pin_b,
    output logic            level_alarm_pin_b_oe,
    output logic            diode_on_alarm_a,
    output logic            dev_clk,
    output logic            dev_tick,
    output logic            half_cycle_shift,
    output logic            fine_delay_en,
    output logic            dp_soft_reset
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic       rst_sync_n;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_sync_ff[1];

    // ------------------------------------------------------------------
    // readback decode
    // ------------------------------------------------------------------
    adcr_regs_state_type r_ff;
    adcr_regs_state_type nxt_r;

    function automatic logic [7:0] rd_reg(input adcr_regs_state_type s,
                                          input logic [14:0]     a);
        if (a == `ADCR_OFS_TEMP_DIODE) begin
            rd_reg = s.temp_diode;
        end else if (a == `ADCR_OFS_FULLSCALE) begin
            rd_reg = s.fullscale;
        end else if (a == `ADCR_OFS_PD_PIN_EN) begin
            rd_reg = s.pd_pin_en;
        end else if (a == `ADCR_OFS_PIN_ROUTE) begin
            rd_reg = s.pin_route;
        end else if (a == `ADCR_OFS_DIV_RATIO) begin
            rd_reg = s.div_ratio;
        end else if (a == `ADCR_OFS_DIV_PHASE) begin
            rd_reg = s.div_phase;
        end else if (a == `ADCR_OFS_AUTOPHASE) begin
            rd_reg = s.autophase;
        end else if (a == `ADCR_OFS_FINE_DLY) begin
            rd_reg = s.fine_dly;
        end else begin
            rd_reg = 8'h00;
        end
    endfunction : rd_reg

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    adcr_div_if div_if ();

    assign div_if.ratio_code = r_ff.div_ratio[2:0];
    assign div_if.phase_code = r_ff.div_phase[3:0];
    assign div_if.realign    = r_ff.realign;

    adcr_clkdiv u_clkdiv (
        .mclk       (mclk),
        .rst_sync_n (rst_sync_n),
        .div        (div_if.div)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic        sclk_rise;
        logic        sclk_fall;
        logic        sdi;
        logic [15:0] word;
        logic [7:0]  wd;
        logic [2:0]  pos_lim;
        logic [2:0]  neg_lim;
        logic        in_win;
        logic        sleep_act;
        sclk_rise = 1'b0;
        sclk_fall = 1'b0;
        sdi       = 1'b0;
        word      = 16'h0000;
        wd        = 8'h00;
        pos_lim   = 3'h0;
        neg_lim   = 3'h0;
        in_win    = 1'b0;
        sleep_act = 1'b0;
        nxt_r     = r_ff;

        nxt_r.csb_sync   = {r_ff.csb_sync[1:0], spi_csb_n};
        nxt_r.sclk_sync  = {r_ff.sclk_sync[1:0], spi_sclk};
        nxt_r.sdio_sync  = {r_ff.sdio_sync[0], spi_sdio_in};
        nxt_r.sleep_sync = {r_ff.sleep_sync[0], sleep_control_pin};
        nxt_r.sync_sync  = {r_ff.sync_sync[1:0], sync_pin};
        sclk_rise = r_ff.sclk_sync[1] & ~r_ff.sclk_sync[2];
        sclk_fall = ~r_ff.sclk_sync[1] & r_ff.sclk_sync[2];
        sdi       = r_ff.sdio_sync[1];

        // serial port: 16-bit instruction then data bytes, MSB first;
        // address steps up after each byte for streaming access
        if (r_ff.csb_sync[1]) begin
            nxt_r.st      = SPI_INSTR;
            nxt_r.bit_cnt = 4'h0;
            nxt_r.oe      = 1'b0;
        end else if (sclk_rise) begin
            word = {r_ff.shift[14:0], sdi};
            nxt_r.shift   = word;
            nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
            case (r_ff.st)
                SPI_INSTR: begin
                    if (r_ff.bit_cnt == 4'hF) begin
                        nxt_r.st      = SPI_DATA;
                        nxt_r.bit_cnt = 4'h0;
                        nxt_r.rd      = word[15];
                        nxt_r.addr    = word[14:0];
                        nxt_r.oe      = word[15];
                        nxt_r.tx      = rd_reg(r_ff, word[14:0]);
                    end
                end
                SPI_DATA: begin
                    if (r_ff.bit_cnt == 4'h7) begin
                        nxt_r.bit_cnt = 4'h0;
                        nxt_r.addr    = r_ff.addr + 15'h0001;
                        nxt_r.tx      = rd_reg(r_ff, r_ff.addr + 15'h0001);
                        wd            = word[7:0];
                        if (!r_ff.rd) begin
                            if (r_ff.addr == `ADCR_OFS_TEMP_DIODE) begin
                                nxt_r.temp_diode = wd
                                    & `ADCR_MSK_TEMP_DIODE;
                            end else if (r_ff.addr == `ADCR_OFS_FULLSCALE) begin
                                nxt_r.fullscale = wd & `ADCR_MSK_FULLSCALE;
                            end else if (r_ff.addr == `ADCR_OFS_PD_PIN_EN) begin
                                nxt_r.pd_pin_en = wd & `ADCR_MSK_PD_PIN_EN;
                            end else if (r_ff.addr == `ADCR_OFS_PIN_ROUTE) begin
                                nxt_r.pin_route = wd & `ADCR_MSK_PIN_ROUTE;
                            end else if (r_ff.addr == `ADCR_OFS_DIV_RATIO) begin
                                nxt_r.div_ratio = wd & `ADCR_MSK_DIV_RATIO;
                            end else if (r_ff.addr == `ADCR_OFS_DIV_PHASE) begin
                                nxt_r.div_phase = wd & `ADCR_MSK_DIV_PHASE;
                            end else if (r_ff.addr == `ADCR_OFS_AUTOPHASE) begin
                                nxt_r.autophase = wd & `ADCR_MSK_AUTOPHASE;
                            end else if (r_ff.addr == `ADCR_OFS_FINE_DLY) begin
                                nxt_r.fine_dly = wd & `ADCR_MSK_FINE_DLY;
                                // only the off-to-on change starts it
                                if (wd[`ADCR_BIT_FINE_DLY] &&
                                    !r_ff.fine_dly[`ADCR_BIT_FINE_DLY]) begin
                                    nxt_r.dp_rst_cnt =
                                        `ADCR_DP_RST_CYCLES;
                                end
                            end
                        end
                    end
                end
                default: begin
                    nxt_r.st = SPI_INSTR;
                end
            endcase
        end else if (sclk_fall && r_ff.oe && r_ff.bit_cnt != 4'h0) begin
            nxt_r.tx = {r_ff.tx[6:0], 1'b0};
        end

        // ------------------------------------------------------------------
        // datapath soft reset, self clearing
        // ------------------------------------------------------------------
        if (nxt_r.dp_rst_cnt == r_ff.dp_rst_cnt &&
            r_ff.dp_rst_cnt != 3'h0) begin
            nxt_r.dp_rst_cnt = r_ff.dp_rst_cnt - 3'h1;
        end
        nxt_r.dp_rst = (nxt_r.dp_rst_cnt != 3'h0);

        // ------------------------------------------------------------------
        // sleep pin
        // ------------------------------------------------------------------
        sleep_act = r_ff.sleep_sync[1] &
                    ~r_ff.pd_pin_en[`ADCR_BIT_PD_IGNORE];
        nxt_r.pd = sleep_act &&
            (r_ff.pin_route[`ADCR_SLEEP_FN_LSB +: 2] ==
             `ADCR_SLEEP_FN_PDWN);
        nxt_r.sb = sleep_act &&
            (r_ff.pin_route[`ADCR_SLEEP_FN_LSB +: 2] ==
             `ADCR_SLEEP_FN_STBY);

        // ------------------------------------------------------------------
        // alarm pins; reserved routes leave the pin undriven
        // ------------------------------------------------------------------
        nxt_r.alarm_a    = fast_detect_a;
        nxt_r.alarm_a_oe = (r_ff.pin_route[`ADCR_ROUTE_A_LSB +: 3] ==
                            `ADCR_ROUTE_DETECT);
        nxt_r.diode_a    = (r_ff.pin_route[`ADCR_ROUTE_A_LSB +: 3] ==
                            `ADCR_ROUTE_DIODE);
        nxt_r.alarm_b    = fast_detect_b;
        nxt_r.alarm_b_oe = (r_ff.pin_route[`ADCR_ROUTE_B_LSB +: 3] ==
                            `ADCR_ROUTE_DETECT);

        // ------------------------------------------------------------------
        // automatic divider phase adjustment
        // ------------------------------------------------------------------
        nxt_r.realign = 1'b0;
        if (div_if.dev_tick) begin
            nxt_r.frame_pos = r_ff.frame_pos + 3'h1;
        end
        neg_lim = {1'b0, r_ff.autophase[`ADCR_NEG_WIN_LSB +: 2]};
        pos_lim = (r_ff.autophase[`ADCR_POS_WIN_LSB +: 2] == 2'h3) ? 3'h2 :
                  {1'b0, r_ff.autophase[`ADCR_POS_WIN_LSB +: 2]};
        in_win  = (r_ff.frame_pos <= pos_lim) ||
                  ((3'h0 - r_ff.frame_pos) <= neg_lim);
        // a divide of one has no phase to adjust
        if (r_ff.autophase[`ADCR_BIT_AUTOPHASE] &&
            (r_ff.div_ratio[2:0] != 3'h0) &&
            r_ff.sync_sync[1] && !r_ff.sync_sync[2] && !in_win) begin
            nxt_r.realign   = 1'b1;
            nxt_r.frame_pos = 3'h0;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r_ff            <= '0;
            r_ff.csb_sync   <= 3'h7;
            r_ff.st         <= SPI_INSTR;
            r_ff.temp_diode <= `ADCR_RST_TEMP_DIODE;
            r_ff.fullscale  <= `ADCR_RST_FULLSCALE;
            r_ff.pd_pin_en  <= `ADCR_RST_PD_PIN_EN;
            r_ff.pin_route  <= `ADCR_RST_PIN_ROUTE;
            r_ff.div_ratio  <= `ADCR_RST_DIV_RATIO;
            r_ff.div_phase  <= `ADCR_RST_DIV_PHASE;
            r_ff.autophase  <= `ADCR_RST_AUTOPHASE;
            r_ff.fine_dly   <= `ADCR_RST_FINE_DLY;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign spi_sdio_out         = r_ff.tx[7];
    assign spi_sdio_oe          = r_ff.oe;
    assign temp_diode_en        = r_ff.temp_diode[`ADCR_BIT_DIODE_SEL];
    assign fullscale_code       = r_ff.fullscale[`ADCR_FS_LSB +: 2];
    assign powerdown_req        = r_ff.pd;
    assign standby_req          = r_ff.sb;
    assign level_alarm_pin_a    = r_ff.alarm_a;
    assign level_alarm_pin_a_oe = r_ff.alarm_a_oe;
    assign level_alarm_pin_b    = r_ff.alarm_b;
    assign level_alarm_pin_b_oe = r_ff.alarm_b_oe;
    assign diode_on_alarm_a     = r_ff.diode_a &
                                  r_ff.temp_diode[`ADCR_BIT_DIODE_SEL];
    assign dev_clk              = div_if.dev_clk;
    assign dev_tick             = div_if.dev_tick;
    assign half_cycle_shift     = div_if.half_shift;
    assign fine_delay_en        = r_ff.fine_dly[`ADCR_BIT_FINE_DLY];
    assign dp_soft_reset        = r_ff.dp_rst;

endmodule : adcr_regs

`default_nettype wire

// ==== dv/adcr_regs_monitor.sv ====
// port assertions for the clock and pin configuration bank
// assumes one mclk domain; bound onto every adcr_regs instance
`timescale 1ns/1ps
`default_nettype none
module adcr_regs_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sleep_control_pin,
    input wire logic fast_detect_a,
    input wire logic fast_detect_b,
    input wire logic temp_diode_en,
    input wire logic powerdown_req,
    input wire logic standby_req,
    input wire logic level_alarm_pin_a,
    input wire logic level_alarm_pin_a_oe,
    input wire logic level_alarm_pin_b,
    input wire logic level_alarm_pin_b_oe,
    input wire logic diode_on_alarm_a,
    input wire logic fine_delay_en,
    input wire logic dp_soft_reset
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_pulse; dp_soft_reset [*4] ##1 !dp_soft_reset; endsequence
    sequence s_pin_low; (!sleep_control_pin) [*6]; endsequence
    chk_pulse_len: assert property ($rose(dp_soft_reset) |-> s_pulse)
        else $error("soft reset pulse length wrong");
    chk_pulse_cause: assert property ($rose(fine_delay_en) |-> $rose(dp_soft_reset))
        else $error("fine delay enable gave no soft reset");
    chk_pulse_rise: assert property ($rose(dp_soft_reset) |-> fine_delay_en)
        else $error("soft reset without fine delay enable");
    chk_alarm_a_copy: assert property (level_alarm_pin_a_oe |->
        level_alarm_pin_a == $past(fast_detect_a)) else $error("alarm a wrong");
    chk_alarm_b_copy: assert property (level_alarm_pin_b_oe |->
        level_alarm_pin_b == $past(fast_detect_b)) else $error("alarm b wrong");
    chk_diode_route: assert property (diode_on_alarm_a |->
        temp_diode_en && !level_alarm_pin_a_oe) else $error("diode route wrong");
    chk_sleep_one: assert property (!(powerdown_req && standby_req))
        else $error("power down and standby together");
    chk_sleep_idle: assert property (s_pin_low |-> !powerdown_req && !standby_req)
        else $error("sleep request without pin");
endmodule : adcr_regs_monitor
bind adcr_regs adcr_regs_monitor adcr_regs_monitor_i (.*);
`default_nettype wire

// ==== dv/tb_adcr_regs.sv ====
// self-checking bench driving the bank through its serial port
// assumes adcr_params.svh on the include path; inputs move on falling mclk
`timescale 1ns/1ps
`default_nettype none
`include "adcr_params.svh"
module tb_adcr_regs;
    logic mclk = 0, rst_n = 0, csb_n = 1, sclk = 0, hbit = 0, slp = 0;
    logic fda = 0, fdb = 0, syn = 0;
    wire logic so, soe, sdio, td, pd, sb, aa, aao, ab, abo, da, dc, tk;
    wire logic hs, fe, dr;
    wire logic [1:0] fs;
    int num_errors = 0, comparisons = 0, drn = 0;
    logic [31:0] rs = 32'd87, rf = 32'd87;
    logic [7:0] mreg [8] = '{8'h00, 8'h04, 8'h00, 8'h3F, 8'h00, 8'h00,
                             8'h00, 8'h00};
    logic [7:0] msk [8] = '{8'h01, 8'h0C, 8'h80, 8'hFF, 8'h07, 8'h0F,
                            8'h8F, 8'h01};
    logic [14:0] ofs [8] = '{`ADCR_OFS_TEMP_DIODE, `ADCR_OFS_FULLSCALE,
        `ADCR_OFS_PD_PIN_EN, `ADCR_OFS_PIN_ROUTE, `ADCR_OFS_DIV_RATIO,
        `ADCR_OFS_DIV_PHASE, `ADCR_OFS_AUTOPHASE, `ADCR_OFS_FINE_DLY};
    logic [7:0] rt [4] = '{8'h00, 8'h7B, 8'h91, 8'hC7};
    logic [2:0] dcode [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    // the sdio wire: device wins while its enable is up
    assign sdio = soe ? so : hbit;
    adcr_regs adcr_regs_i (.mclk(mclk), .rst_n(rst_n), .spi_csb_n(csb_n),
        .spi_sclk(sclk), .spi_sdio_in(sdio), .spi_sdio_out(so),
        .spi_sdio_oe(soe), .sleep_control_pin(slp), .sync_pin(syn),
        .fast_detect_a(fda), .fast_detect_b(fdb), .temp_diode_en(td),
        .fullscale_code(fs), .powerdown_req(pd), .standby_req(sb),
        .level_alarm_pin_a(aa), .level_alarm_pin_a_oe(aao),
        .level_alarm_pin_b(ab), .level_alarm_pin_b_oe(abo),
        .diode_on_alarm_a(da), .dev_clk(dc), .dev_tick(tk),
        .half_cycle_shift(hs), .fine_delay_en(fe), .dp_soft_reset(dr));
    always #12.5 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        xs = v ^ (v << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction : xs
    always @(negedge mclk) begin
        rf = xs(rf);
        fda = rf[0];
        fdb = rf[1];
        drn += dr;
    end
    task automatic conclude();
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // sclk low for 5 mclk and high for 6 mclk keeps well inside the sync margin
    task automatic spi(input logic [23:0] w, output logic [7:0] q);
        @(negedge mclk) csb_n = 0;
        for (int i = 23; i >= 0; i--) begin
            @(negedge mclk) sclk = 0;
            hbit = w[i];
            repeat (5) @(negedge mclk);
            q = {q[6:0], sdio};
            sclk = 1;
            repeat (5) @(negedge mclk);
        end
        sclk = 0;
        csb_n = 1;
        repeat (8) @(negedge mclk);
    endtask : spi
    task automatic outs();
        logic [2:0] ra;
        ra = mreg[3][2:0];
        check(td, mreg[0][0]);
        check(fs, mreg[1][3:2]);
        check(pd, slp & !mreg[2][7] & (mreg[3][7:6] == 2'h0));
        check(sb, slp & !mreg[2][7] & (mreg[3][7:6] == 2'h1));
        check(aao, ra == 3'h0);
        check(abo, mreg[3][5:3] == 3'h0);
        check(da, ra == 3'h3 && mreg[0][0]);
        check(hs, mreg[5][0]);
        check(fe, mreg[7][0]);
    endtask : outs
    task automatic wr(input int k, input logic [7:0] d);
        logic [7:0] q;
        spi({1'b0, ofs[k], d}, q);
        mreg[k] = d & msk[k];
        outs();
    endtask : wr
    task automatic rd(input int k);
        logic [7:0] q;
        spi({1'b1, ofs[k], 8'h00}, q);
        check(q, mreg[k]);
    endtask : rd
    initial begin
        logic [7:0] q;
        int c0, c1;
        repeat (4) @(negedge mclk);
        rst_n = 1;
        repeat (6) @(negedge mclk);
        outs();
        for (int k = 0; k < 8; k++) rd(k);
        spi({1'b0, 15'h0029, 8'hFF}, q);
        spi({1'b1, 15'h0029, 8'h00}, q);
        check(q, 8'h00);
        for (int k = 0; k < 8; k++) begin
            rs = xs(rs);
            wr(k, rs[7:0]);
        end
        for (int k = 0; k < 8; k++) rd(k);
        slp = 1;
        wr(0, 8'h01);
        wr(2, 8'h00);
        foreach (rt[j]) wr(3, rt[j]);
        wr(2, 8'h80);
        wr(3, 8'h40);
        wr(6, 8'h00);
        foreach (dcode[j]) begin
            wr(4, {5'h00, dcode[j]});
            c0 = 0;
            c1 = 0;
            repeat (64) @(negedge mclk) begin
                c0 += tk;
                c1 += dc;
            end
            check(8'(c0), 8'(64 >> j));
            check(8'(c1), (j == 0) ? 8'h40 : 8'h20);
        end
        // divide by 8 still set, so autophase may be relied on now
        wr(6, 8'h80);
        // gaps differ by 3 cycles: without realignment the phase moves
        for (int j = 0; j < 3; j++) begin
            repeat (13 + 3 * j) @(negedge mclk);
            syn = 1;
            repeat (16) @(negedge mclk);
            syn = 0;
            c1 = 0;
            while (!tk) begin
                @(negedge mclk);
                c1++;
            end
            if (j == 1) c0 = c1;
            if (j == 2) check(8'(c1), 8'(c0));
        end
        wr(7, 8'h00);
        c0 = drn;
        wr(7, 8'h01);
        check(8'(drn - c0), 8'h04);
        conclude();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        conclude();
    end
endmodule : tb_adcr_regs
`default_nettype wire
